// ### inc/ilkb_pkg.sv
package ilkb_pkg;

   // key geometry
   localparam int KEY_W = 371;
   localparam int POS_TYPE = 0;
   localparam int POS_FIRST = 2;
   localparam int POS_PGRP = 3;
   localparam int POS_IGR = 11;
   localparam int POS_RSVD = 23;
   localparam int POS_HOST = 24;
   localparam int POS_MC = 25;
   localparam int POS_BC = 26;
   localparam int POS_TAGGED = 27;
   localparam int POS_VID = 28;
   localparam int POS_DEI = 40;
   localparam int POS_PCP = 41;
   localparam int POS_HOPNZ = 44;
   localparam int POS_TCLASS = 45;
   localparam int POS_DIP = 53;
   localparam int POS_SIP = 181;
   localparam int POS_ADDREQ = 309;
   localparam int POS_PROTO6 = 310;
   localparam int POS_DPORT = 311;
   localparam int POS_SPORT = 327;
   localparam int POS_RNG = 343;
   localparam int POS_PORTEQ = 351;
   localparam int POS_SEQZ = 352;
   localparam int POS_FLAGS = 353;
   localparam int POS_DOM = 359;
   localparam int POS_VER = 367;

   localparam int NUM_PORTS = 12;
   localparam int NUM_RNG = 8;
   localparam int MC_BIT = 40;

   // key type codes
   localparam logic [1:0] KT_L4 = 2'h0;
   localparam logic [1:0] KT_MISC = 2'h1;
   localparam logic [1:0] KT_CUSTOM = 2'h2;

   // protocol numbers and broadcast mac
   localparam logic [7:0] PROTO_TCP = 8'h06;
   localparam logic [7:0] PROTO_UDP = 8'h11;
   localparam logic [47:0] MAC_BCAST = 48'hffffffffffff;

   // range checker types
   localparam logic [2:0] RT_OFF = 3'h0;
   localparam logic [2:0] RT_SPORT = 3'h1;
   localparam logic [2:0] RT_DPORT = 3'h2;
   localparam logic [2:0] RT_EITHER = 3'h3;
   localparam logic [2:0] RT_VID = 3'h4;
   localparam logic [2:0] RT_DSCP = 3'h5;

   // apb map
   localparam logic [7:0] OFS_RNG_TYPE = 8'h00;
   localparam logic [7:0] OFS_RNG_BOUNDS = 8'h20;
   localparam logic [7:0] OFS_CTRL = 8'h40;
   localparam logic [7:0] OFS_KEY_COUNT = 8'h44;
   localparam logic CTRL_EN_RST = 1'b0;
   localparam int CTRL_EN_BIT = 0;

   typedef logic [KEY_W-1:0] ilkb_key_t;

   typedef struct packed {
      logic valid;
      logic first_lookup;
      logic [7:0] policy_group;
      logic [3:0] ingress_port;
      logic mac_ipv4_host_lookup;
      logic mac_ipv6_host_lookup;
      logic [47:0] dmac;
      logic [1:0] qtag_count;
      logic [11:0] vid;
      logic dei;
      logic [2:0] pcp;
      logic [5:0] dscp;
      logic [7:0] hop_limit;
      logic [7:0] traffic_class_field;
      logic [127:0] dest_ipv6_addr;
      logic [127:0] src_ipv6_addr;
      logic [7:0] next_header;
      logic [15:0] dest_port_field;
      logic [15:0] src_port_field;
      logic [31:0] tcp_seq;
      logic [5:0] tcp_flags;
      logic is_ptp;
      logic [3:0] ptp_msg_type;
      logic [7:0] ptp_flag_field;
      logic [7:0] ptp_domain_field;
      logic [3:0] ptp_version_field;
   } ilkb_frame_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ilkb_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ilkb_apb_rsp_t;

endpackage

// ### core/ilkb_full_key_builder.sv
// Behaviour
// RULE1: key type zero at bit 0
// RULE2: bit 2 high on first lookup
// RULE3: policy group copied at bit 3
// RULE4: one-hot ingress port mask at bit 11
// RULE5: programmer masks reserved bit 23
// RULE6: host lookup result at bit 24
// RULE7: multicast flag from dmac bit 40
// RULE8: broadcast flag on all-ones dmac
// RULE9: tagged flag when any q-tag present
// RULE10: classified vid, dei, pcp at 28/40/41
// RULE11: bit 44 when hop limit nonzero
// RULE12: traffic class and both addresses placed
// RULE13: bit 309 when addresses equal
// RULE14: bit 310 when next header is six
// RULE15: destination and source ports placed
// RULE16: eight-bit range match vector at 343
// RULE17: range types port, vid, dscp supported
// RULE18: bit 351 when ports equal
// RULE19: bit 352 seq zero or ptp type0
// RULE20: tcp flags at bits 353 to 358
// RULE21: ptp message type bits at 353-355
// RULE22: ptp flag bits at 356-358
// RULE23: ptp domain number at bit 359
// RULE24: ptp version at bit 367
module ilkb_full_key_builder (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // frame descriptor
   input wire ilkb_pkg::ilkb_frame_t frm,
   // key out
   output ilkb_pkg::ilkb_key_t key,
   output logic key_valid,
   // apb
   input wire ilkb_pkg::ilkb_apb_req_t apb_req,
   output ilkb_pkg::ilkb_apb_rsp_t apb_rsp
);

   typedef struct packed {
      logic [ilkb_pkg::NUM_RNG-1:0][2:0] rng_type;
      logic [ilkb_pkg::NUM_RNG-1:0][31:0] rng_bounds;
      logic enable;
      logic [31:0] key_count;
      ilkb_pkg::ilkb_key_t key;
      logic key_valid;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ilkb_state_t;

   ilkb_state_t q;
   ilkb_state_t d;

   function automatic logic in_range(input logic [15:0] v,
                                     input logic [31:0] bounds);
      in_range = (v >= bounds[15:0]) && (v <= bounds[31:16]);
   endfunction

   // range checkers
   logic [ilkb_pkg::NUM_RNG-1:0] rng_hit;
   always_comb begin
      for (int i = 0; i < ilkb_pkg::NUM_RNG; i++) begin
         unique case (q.rng_type[i]) // RULE16 RULE17
            ilkb_pkg::RT_SPORT:
               rng_hit[i] = in_range(frm.src_port_field, q.rng_bounds[i]);
            ilkb_pkg::RT_DPORT:
               rng_hit[i] = in_range(frm.dest_port_field, q.rng_bounds[i]);
            ilkb_pkg::RT_EITHER:
               rng_hit[i] = in_range(frm.src_port_field, q.rng_bounds[i])
                  || in_range(frm.dest_port_field, q.rng_bounds[i]);
            ilkb_pkg::RT_VID:
               rng_hit[i] = in_range({4'h0, frm.vid}, q.rng_bounds[i]);
            ilkb_pkg::RT_DSCP:
               rng_hit[i] = in_range({10'h000, frm.dscp}, q.rng_bounds[i]);
            default:
               rng_hit[i] = 1'b0;
         endcase
      end
   end

   // apb decode
   logic apb_access;
   logic apb_hit;
   logic apb_ro;
   logic [31:0] apb_rdata;
   logic [2:0] apb_idx;
   always_comb begin
      apb_access = apb_req.psel && apb_req.penable;
      apb_idx = apb_req.paddr[4:2];
      apb_hit = 1'b1;
      apb_ro = 1'b0;
      apb_rdata = 32'h0000_0000;
      if (apb_req.paddr[1:0] != 2'h0) begin
         apb_hit = 1'b0;
      end else if (apb_req.paddr[7:5] == ilkb_pkg::OFS_RNG_TYPE[7:5]) begin
         apb_rdata = {29'h0000_0000, q.rng_type[apb_idx]};
      end else if (apb_req.paddr[7:5] ==
                   ilkb_pkg::OFS_RNG_BOUNDS[7:5]) begin
         apb_rdata = q.rng_bounds[apb_idx];
      end else if (apb_req.paddr == ilkb_pkg::OFS_CTRL) begin
         apb_rdata = {31'h0000_0000, q.enable};
      end else if (apb_req.paddr == ilkb_pkg::OFS_KEY_COUNT) begin
         apb_rdata = q.key_count;
         apb_ro = 1'b1;
      end else begin
         apb_hit = 1'b0;
      end
   end

   // tcp and ptp over udp recognition
   logic is_tcp;
   logic is_ptp_udp;
   always_comb begin
      is_tcp = frm.next_header == ilkb_pkg::PROTO_TCP;
      is_ptp_udp = frm.is_ptp && (frm.next_header == ilkb_pkg::PROTO_UDP);
   end

   always_comb begin
      d = q;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      // one wait state, answer registered
      if (apb_access && !q.pready) begin
         d.pready = 1'b1;
         d.prdata = apb_req.pwrite ? 32'h0000_0000 : apb_rdata;
         d.pslverr = !apb_hit;
      end
      if (apb_access && q.pready && apb_req.pwrite && apb_hit && !apb_ro)
      begin
         if (apb_req.paddr[7:5] == ilkb_pkg::OFS_RNG_TYPE[7:5]) begin
            d.rng_type[apb_idx] = apb_req.pwdata[2:0];
         end else if (apb_req.paddr[7:5] ==
                      ilkb_pkg::OFS_RNG_BOUNDS[7:5]) begin
            d.rng_bounds[apb_idx] = apb_req.pwdata;
         end else begin
            d.enable = apb_req.pwdata[ilkb_pkg::CTRL_EN_BIT];
         end
      end

      d.key_valid = 1'b0;
      if (frm.valid && q.enable) begin
         d.key_valid = 1'b1;
         d.key_count = q.key_count + 32'h0000_0001;
         d.key = '0;
         d.key[ilkb_pkg::POS_TYPE +: 2] = ilkb_pkg::KT_L4; // RULE1
         d.key[ilkb_pkg::POS_FIRST] = frm.first_lookup; // RULE2
         d.key[ilkb_pkg::POS_PGRP +: 8] = frm.policy_group; // RULE3
         d.key[ilkb_pkg::POS_IGR +: ilkb_pkg::NUM_PORTS] =
            12'h001 << frm.ingress_port; // RULE4
         // reserved bit left low, entries mask it
         d.key[ilkb_pkg::POS_RSVD] = 1'b0; // RULE5
         d.key[ilkb_pkg::POS_HOST] = frm.mac_ipv4_host_lookup
            || frm.mac_ipv6_host_lookup; // RULE6
         d.key[ilkb_pkg::POS_MC] = frm.dmac[ilkb_pkg::MC_BIT]; // RULE7
         d.key[ilkb_pkg::POS_BC] = frm.dmac == ilkb_pkg::MAC_BCAST; // RULE8
         d.key[ilkb_pkg::POS_TAGGED] = frm.qtag_count != 2'h0; // RULE9
         d.key[ilkb_pkg::POS_VID +: 12] = frm.vid; // RULE10
         d.key[ilkb_pkg::POS_DEI] = frm.dei; // RULE10
         d.key[ilkb_pkg::POS_PCP +: 3] = frm.pcp; // RULE10
         d.key[ilkb_pkg::POS_HOPNZ] = frm.hop_limit != 8'h00; // RULE11
         d.key[ilkb_pkg::POS_TCLASS +: 8] = frm.traffic_class_field; // RULE12
         d.key[ilkb_pkg::POS_DIP +: 128] = frm.dest_ipv6_addr; // RULE12
         d.key[ilkb_pkg::POS_SIP +: 128] = frm.src_ipv6_addr; // RULE12
         d.key[ilkb_pkg::POS_ADDREQ] =
            frm.src_ipv6_addr == frm.dest_ipv6_addr; // RULE13
         d.key[ilkb_pkg::POS_PROTO6] = is_tcp; // RULE14
         d.key[ilkb_pkg::POS_DPORT +: 16] = frm.dest_port_field; // RULE15
         d.key[ilkb_pkg::POS_SPORT +: 16] = frm.src_port_field; // RULE15
         d.key[ilkb_pkg::POS_RNG +: ilkb_pkg::NUM_RNG] = rng_hit; // RULE16
         d.key[ilkb_pkg::POS_PORTEQ] =
            frm.src_port_field == frm.dest_port_field; // RULE18
         if (is_tcp) begin
            d.key[ilkb_pkg::POS_SEQZ] = frm.tcp_seq == 32'h0000_0000; // RULE19
            d.key[ilkb_pkg::POS_FLAGS +: 6] = frm.tcp_flags; // RULE20
         end else if (is_ptp_udp) begin
            d.key[ilkb_pkg::POS_SEQZ] = frm.ptp_msg_type[0]; // RULE19
            d.key[ilkb_pkg::POS_FLAGS +: 3] = frm.ptp_msg_type[3:1]; // RULE21
            d.key[ilkb_pkg::POS_FLAGS + 3] = frm.ptp_flag_field[1]; // RULE22
            d.key[ilkb_pkg::POS_FLAGS + 4] = frm.ptp_flag_field[2]; // RULE22
            d.key[ilkb_pkg::POS_FLAGS + 5] = frm.ptp_flag_field[7]; // RULE22
            d.key[ilkb_pkg::POS_DOM +: 8] = frm.ptp_domain_field; // RULE23
            d.key[ilkb_pkg::POS_VER +: 4] = frm.ptp_version_field; // RULE24
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '0;
         q.enable <= ilkb_pkg::CTRL_EN_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   assign key = q.key;
   assign key_valid = q.key_valid;
   assign apb_rsp.prdata = q.prdata;
   assign apb_rsp.pready = q.pready;
   assign apb_rsp.pslverr = q.pslverr;

   // checks
   logic take;
   assign take = ce && frm.valid && q.enable;

   a_key_type_l4: assert property ( // RULE1
      @(posedge clk) disable iff (!reset_n)
      take |=> key_valid && key[1:0] == 2'h0)
      else $error("key type not zero");

   a_first_lookup_bit: assert property ( // RULE2
      @(posedge clk) disable iff (!reset_n)
      take |=> key[2] == $past(frm.first_lookup))
      else $error("lookup order bit wrong");

   a_policy_group_copy: assert property ( // RULE3
      @(posedge clk) disable iff (!reset_n)
      take |=> key[10:3] == $past(frm.policy_group))
      else $error("policy group wrong");

   a_ingress_onehot: assert property ( // RULE4
      @(posedge clk) disable iff (!reset_n)
      take && frm.ingress_port < 4'hc |=> $onehot(key[22:11])
         && key[11 + $past(frm.ingress_port)])
      else $error("ingress mask not one-hot on port");

   a_host_lookup_bit: assert property ( // RULE6
      @(posedge clk) disable iff (!reset_n)
      take |=> key[24] == ($past(frm.mac_ipv4_host_lookup)
         || $past(frm.mac_ipv6_host_lookup)))
      else $error("host lookup bit wrong");

   a_mcast_bcast_flags: assert property ( // RULE7 RULE8
      @(posedge clk) disable iff (!reset_n)
      take |=> key[25] == $past(frm.dmac[40])
         && key[26] == (&$past(frm.dmac)))
      else $error("cast flags wrong");

   a_tagged_vlan: assert property ( // RULE9 RULE10
      @(posedge clk) disable iff (!reset_n)
      take |=> key[27] == ($past(frm.qtag_count) != 2'h0)
         && key[43:28] == {$past(frm.pcp), $past(frm.dei), $past(frm.vid)})
      else $error("vlan fields wrong");

   a_l3_fields: assert property ( // RULE11 RULE12 RULE13 RULE14
      @(posedge clk) disable iff (!reset_n)
      take |=> key[44] == ($past(frm.hop_limit) != 8'h00)
         && key[180:53] == $past(frm.dest_ipv6_addr)
         && key[308:181] == $past(frm.src_ipv6_addr)
         && key[309] == ($past(frm.src_ipv6_addr)
            == $past(frm.dest_ipv6_addr))
         && key[310] == ($past(frm.next_header) == 8'h06))
      else $error("layer-3 fields wrong");

   a_l4_ports: assert property ( // RULE15 RULE18
      @(posedge clk) disable iff (!reset_n)
      take |=> key[342:311] == {$past(frm.src_port_field),
         $past(frm.dest_port_field)}
         && key[351] == (key[342:327] == key[326:311]))
      else $error("port fields wrong");

   a_range_off_quiet: assert property ( // RULE16 RULE17
      @(posedge clk) disable iff (!reset_n)
      take && q.rng_type[0] == 3'h0 |=> !key[343])
      else $error("disabled range checker matched");

   a_tcp_flags: assert property ( // RULE19 RULE20
      @(posedge clk) disable iff (!reset_n)
      take && frm.next_header == 8'h06 |=>
         key[358:353] == $past(frm.tcp_flags)
         && key[352] == ($past(frm.tcp_seq) == 32'h0000_0000)
         && key[370:359] == 12'h000)
      else $error("tcp flag bits wrong");

   a_ptp_fields: assert property ( // RULE21 RULE22 RULE23 RULE24
      @(posedge clk) disable iff (!reset_n)
      take && frm.is_ptp && frm.next_header == 8'h11 |=>
         key[355:352] == $past(frm.ptp_msg_type)
         && key[358:356] == {$past(frm.ptp_flag_field[7]),
            $past(frm.ptp_flag_field[2]), $past(frm.ptp_flag_field[1])}
         && key[366:359] == $past(frm.ptp_domain_field)
         && key[370:367] == $past(frm.ptp_version_field))
      else $error("ptp fields wrong");

   a_apb_one_wait: assert property (
      @(posedge clk) disable iff (!reset_n)
      ce && apb_req.psel && apb_req.penable && !apb_rsp.pready
         |=> apb_rsp.pready)
      else $error("apb answer late");

   a_tclass_copy: assert property ( // RULE12
      @(posedge clk) disable iff (!reset_n)
      take |=> key[52:45] == $past(frm.traffic_class_field))
      else $error("traffic class wrong");

   a_reserved_low: assert property ( // RULE5
      @(posedge clk) disable iff (!reset_n)
      take |=> !key[23])
      else $error("reserved key bit set");

   a_no_stray_key: assert property (
      @(posedge clk) disable iff (!reset_n)
      ce && !take |=> !key_valid)
      else $error("key valid without request");

   a_key_holds: assert property (
      @(posedge clk) disable iff (!reset_n)
      !take |=> $stable(key))
      else $error("key changed without request");

   a_range_sport: assert property ( // RULE16 RULE17
      @(posedge clk) disable iff (!reset_n)
      take && q.rng_type[1] == ilkb_pkg::RT_SPORT |=>
         key[344] == ($past(frm.src_port_field)
            >= $past(q.rng_bounds[1][15:0])
            && $past(frm.src_port_field)
            <= $past(q.rng_bounds[1][31:16])))
      else $error("source port range wrong");

   a_range_either: assert property ( // RULE16 RULE17
      @(posedge clk) disable iff (!reset_n)
      take && q.rng_type[3] == ilkb_pkg::RT_EITHER
         && frm.src_port_field >= q.rng_bounds[3][15:0]
         && frm.src_port_field <= q.rng_bounds[3][31:16] |=> key[346])
      else $error("either port range missed");

   a_range_vid: assert property ( // RULE17
      @(posedge clk) disable iff (!reset_n)
      take && q.rng_type[4] == ilkb_pkg::RT_VID |=>
         key[347] == ({4'h0, $past(frm.vid)}
            >= $past(q.rng_bounds[4][15:0])
            && {4'h0, $past(frm.vid)} <= $past(q.rng_bounds[4][31:16])))
      else $error("vid range wrong");

   a_plain_udp_tail: assert property ( // RULE19 RULE20
      @(posedge clk) disable iff (!reset_n)
      take && frm.next_header != ilkb_pkg::PROTO_TCP && !frm.is_ptp
         |=> key[370:352] == 19'h0_0000)
      else $error("plain udp tail not zero");

   a_count_step: assert property (
      @(posedge clk) disable iff (!reset_n)
      take |=> q.key_count == $past(q.key_count) + 32'h0000_0001)
      else $error("key count not stepped");

   a_count_read_only: assert property (
      @(posedge clk) disable iff (!reset_n)
      ce && !take && apb_req.psel && apb_req.penable && apb_req.pwrite
         && apb_req.paddr == ilkb_pkg::OFS_KEY_COUNT
         |=> $stable(q.key_count))
      else $error("key count written");

   a_pready_pulse: assert property (
      @(posedge clk) disable iff (!reset_n)
      ce && apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready stuck high");

   a_bad_addr_err: assert property (
      @(posedge clk) disable iff (!reset_n)
      ce && apb_req.psel && apb_req.penable && !apb_rsp.pready
         && apb_req.paddr[1:0] != 2'h0
         |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
      else $error("unaligned access not refused");

   a_ce_freeze: assert property (
      @(posedge clk) disable iff (!reset_n)
      !ce |=> $stable(key) && $stable(key_valid) && $stable(apb_rsp))
      else $error("state moved with enable low");

endmodule

// ### tb/ilkb_match_model.sv
module ilkb_match_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // key from builder
   input wire ilkb_pkg::ilkb_key_t key,
   input wire logic key_valid,
   // captured key
   output ilkb_pkg::ilkb_key_t seen_key,
   output logic seen
);
   timeunit 1ns;
   timeprecision 1ns;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         seen <= 1'b0;
         seen_key <= '0;
      end else begin
         seen <= key_valid;
         // reserved position is never matched on
         if (key_valid) seen_key <= key & ~(371'(1) << 23);
      end
   end
endmodule

// ### tb/tb_ipv6_l4_full_key_builder.sv
module tb_ipv6_l4_full_key_builder;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   ilkb_pkg::ilkb_frame_t frm = '0;
   ilkb_pkg::ilkb_key_t key;
   ilkb_pkg::ilkb_key_t seen_key;
   logic key_valid;
   logic seen;
   ilkb_pkg::ilkb_apb_req_t apb_req = '0;
   ilkb_pkg::ilkb_apb_rsp_t apb_rsp;
   ilkb_pkg::ilkb_key_t exp_q[$];
   logic [31:0] seed = 32'hdeca;
   logic [2:0] rt[8];
   logic [15:0] lo[8];
   logic [15:0] hi[8];
   int fail_count = 0;
   int n_tests = 0;
   int n_keys = 0;

   always #25 clk = ~clk;

   ilkb_full_key_builder ilkb_full_key_builder_inst (
      .clk(clk), .reset_n(reset_n), .ce(ce), .frm(frm), .key(key),
      .key_valid(key_valid), .apb_req(apb_req), .apb_rsp(apb_rsp));

   ilkb_match_model ilkb_match_model_inst (
      .clk(clk), .reset_n(reset_n), .key(key), .key_valid(key_valid),
      .seen_key(seen_key), .seen(seen));

   function logic [31:0] rnd();
      for (int i = 0; i < 32; i++) begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      end
      return seed;
   endfunction

   task stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task check(input ilkb_pkg::ilkb_key_t seen_v,
              input ilkb_pkg::ilkb_key_t exp_v);
      n_tests++;
      if (seen_v !== exp_v) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
      end
   endtask

   function ilkb_pkg::ilkb_frame_t mk(input int kind);
      logic [479:0] r;
      ilkb_pkg::ilkb_frame_t f;
      for (int i = 0; i < 15; i++) r[i*32 +: 32] = rnd();
      f = r[$bits(f)-1:0];
      f.valid = 1'b1;
      f.ingress_port = f.ingress_port % 4'hc;
      f.next_header = f.tcp_seq[0] ? 8'h06 : 8'h11;
      case (kind)
         1: f.dmac = 48'hffffffffffff;
         2: begin
            f.src_ipv6_addr = f.dest_ipv6_addr;
            f.src_port_field = f.dest_port_field;
         end
         3: begin
            f.hop_limit = 8'h00;
            f.tcp_seq = 32'h0;
            f.next_header = 8'h06;
            f.qtag_count = 2'h0;
         end
         4: {f.next_header, f.is_ptp} = {8'h11, 1'b1};
         5: {f.next_header, f.is_ptp} = {8'h06, 1'b1};
         default: ;
      endcase
      return f;
   endfunction

   function ilkb_pkg::ilkb_key_t exp_key(input ilkb_pkg::ilkb_frame_t f);
      ilkb_pkg::ilkb_key_t k;
      logic [15:0] v;
      logic proto_six_flag;
      k = '0;
      proto_six_flag = f.next_header == 8'h06;
      k[2] = f.first_lookup;
      k[10:3] = f.policy_group;
      k[11 + f.ingress_port] = 1'b1;
      k[24] = f.mac_ipv4_host_lookup | f.mac_ipv6_host_lookup;
      k[25] = f.dmac[40];
      k[26] = f.dmac == 48'hffffffffffff;
      k[27] = f.qtag_count != 2'h0;
      k[43:28] = {f.pcp, f.dei, f.vid};
      k[44] = f.hop_limit != 8'h00;
      k[308:45] = {f.src_ipv6_addr, f.dest_ipv6_addr,
                   f.traffic_class_field};
      k[309] = f.src_ipv6_addr == f.dest_ipv6_addr;
      k[310] = proto_six_flag;
      k[342:311] = {f.src_port_field, f.dest_port_field};
      for (int i = 0; i < 8; i++) begin
         v = rt[i] == 3'h1 ? f.src_port_field : rt[i] == 3'h4 ?
             {4'h0, f.vid} : rt[i] == 3'h5 ? {10'h0, f.dscp} :
             f.dest_port_field;
         k[343 + i] = rt[i] != 3'h0 && (v >= lo[i] && v <= hi[i] ||
            rt[i] == 3'h3 && f.src_port_field >= lo[i] &&
            f.src_port_field <= hi[i]);
      end
      k[351] = f.src_port_field == f.dest_port_field;
      if (proto_six_flag) k[358:352] = {f.tcp_flags, f.tcp_seq == 32'h0};
      else if (f.is_ptp && f.next_header == 8'h11)
         k[370:352] = {f.ptp_version_field,
         f.ptp_domain_field, f.ptp_flag_field[7], f.ptp_flag_field[2:1],
         f.ptp_msg_type};
      return k;
   endfunction

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                   pwdata: d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (apb_rsp.pready !== 1'b1) begin
         fail_count++;
         stop_test();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] d, input logic e);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      check(ilkb_pkg::ilkb_key_t'({err, rd}), ilkb_pkg::ilkb_key_t'({e, d}));
   endtask

   task send(input ilkb_pkg::ilkb_frame_t f, input logic take);
      @(posedge clk);
      frm <= f;
      if (take) begin
         exp_q.push_back(exp_key(f));
         n_keys++;
      end
   endtask

   // compare each delivered key against the oldest note
   always @(posedge clk) begin
      if (seen === 1'b1) begin
         if (exp_q.size() == 0) check(seen_key, 'x);
         else check(seen_key, exp_q.pop_front());
      end
   end

   initial begin
      logic [31:0] rd;
      logic e;
      int s;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rdc(ilkb_pkg::OFS_CTRL, 32'h0, 1'b0);
      send(mk(0), 1'b0);
      @(posedge clk) frm.valid <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rt[i] = 3'(i % 6);
         s = rt[i] == 3'h4 ? 4 : rt[i] == 3'h5 ? 10 : 0;
         rd = rnd();
         lo[i] = 16'(rd[14:0]) >> s;
         hi[i] = lo[i] + (16'h4000 >> s);
         apb(1'b1, 8'(4 * i), {29'h0, rt[i]}, rd, e);
         apb(1'b1, 8'h20 + 8'(4 * i), {hi[i], lo[i]}, rd, e);
         rdc(8'(4 * i), {29'h0, rt[i]}, 1'b0);
      end
      apb(1'b1, ilkb_pkg::OFS_CTRL, 32'h1, rd, e);
      for (int i = 0; i < 36; i++) send(mk(i % 6), 1'b1);
      @(posedge clk) frm.valid <= 1'b0;
      repeat (2) @(posedge clk);
      ce <= 1'b0;
      frm <= mk(0);
      @(posedge clk) frm.valid <= 1'b0;
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(ilkb_pkg::OFS_KEY_COUNT, 32'(n_keys), 1'b0);
      apb(1'b1, ilkb_pkg::OFS_KEY_COUNT, 32'h5a5a, rd, e);
      rdc(ilkb_pkg::OFS_KEY_COUNT, 32'(n_keys), 1'b0);
      rdc(8'h80, 32'h0, 1'b1);
      rdc(8'h41, 32'h0, 1'b1);
      @(posedge clk) reset_n <= 1'b0;
      @(posedge clk) reset_n <= 1'b1;
      rdc(ilkb_pkg::OFS_CTRL, 32'h0, 1'b0);
      rdc(ilkb_pkg::OFS_KEY_COUNT, 32'h0, 1'b0);
      rdc(ilkb_pkg::OFS_RNG_TYPE + 8'h04, 32'h0, 1'b0);
      if (exp_q.size() != 0) fail_count++;
      stop_test();
   end
endmodule
